/* File: ccad_decoder.sv */
// host i/o configuration address and data port decoder
//
// Contract
// - address register claimed only for full dword access; bits 31 and 23:2 rw
// - byte or word access to address port passes downstream as an i/o pass cycle
// - bit 31 gates translation of data window accesses
// - bits 30:24 read zero; bits 1:0 reserved
// - bus zero, device three or more: forward cycle on hub a
// - bus zero, device 0..2: select internal function, kept internal
// - bus equals graphics secondary: type 0 on graphics port
// - bus in graphics secondary..subordinate range: type 1 on graphics
// - bus equals hub b secondary: type 0 on hub b
// - bus in hub b range: type 1 on hub b
// - nonzero bus outside both ranges goes to hub a
// - graphics type 0 with bit 15 clear: bits 14:11 pick one select among 31:16
// - hub cycles carry device field on address 15:11
// - function field on address 10:8 for all config cycles
// - internal function accesses with nonzero function ignored
// - register field drives address 7:2
// - gate set: data window access becomes config cycle
// - graphics bridge primary bus number is hardwired zero
`timescale 1ns/1ps
`default_nettype none
`include "ccad_params.svh"
module ccad_decoder
(
   // clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 rst_n,
   // host i/o request
   input  wire ccad_pkg::ccad_io_req_t io_req,
   // bridge bus number windows
   input  wire logic [7:0]           gfx_sec_bus,
   input  wire logic [7:0]           gfx_sub_bus,
   input  wire logic [7:0]           hubb_sec_bus,
   input  wire logic [7:0]           hubb_sub_bus,
   // downstream completion
   input  wire logic                 cyc_done,
   input  wire logic [31:0]          cyc_rdata,
   // host answer
   output logic                      io_ack,
   output logic [31:0]               io_rdata,
   output logic                      io_busy,
   // downstream cycle
   output ccad_pkg::ccad_cycle_t     cyc_out,
   // state
   output logic [31:0]               addr_sel_out,
   output logic [7:0]                gfx_primary_bus
);
   typedef enum logic [1:0] {
      CCAD_IDLE,
      CCAD_WAIT
   } ccad_state_t;

   ccad_state_t            state_q;
   logic [31:0]            addr_q;
   ccad_pkg::ccad_cycle_t  cyc_q;
   ccad_pkg::ccad_cycle_t  cyc_d;
   logic                   ack_q;
   logic [31:0]            rdata_q;
   logic                   busy_q;
   ccad_pkg::ccad_target_t tgt;
   logic                   type1;
   logic [1:0]             int_func;
   logic [31:0]            route_addr;
   logic                   take;
   logic                   is_addr;
   logic                   is_data;
   logic                   full_dw;

   ccad_route u_route
   (
      .addr_sel     (addr_q),
      .gfx_sec_bus  (gfx_sec_bus),
      .gfx_sub_bus  (gfx_sub_bus),
      .hubb_sec_bus (hubb_sec_bus),
      .hubb_sub_bus (hubb_sub_bus),
      .target       (tgt),
      .type1        (type1),
      .int_func     (int_func),
      .out_addr     (route_addr)
   );

   assign take    = io_req.valid && (state_q == CCAD_IDLE);
   assign is_addr = (io_req.port == `CCAD_ADDR_PORT);
   assign is_data = (io_req.port == `CCAD_DATA_PORT);
   assign full_dw = (io_req.byte_en == 4'hf);

   // address register
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         addr_q <= `CCAD_ADDR_RESET;
      else if (take && is_addr && full_dw && io_req.write)
         addr_q <= io_req.wdata & `CCAD_WR_MASK;
   end

   // next downstream cycle
   always_comb
   begin
      cyc_d           = '0;
      cyc_d.write     = io_req.write;
      cyc_d.byte_en   = io_req.byte_en;
      cyc_d.wdata     = io_req.wdata;
      cyc_d.addr      = {16'h0000, io_req.port};
      cyc_d.target    = ccad_pkg::CCAD_TGT_IO_PASS;
      if (take)
      begin
         if (is_addr && !full_dw)
            cyc_d.valid = 1'b1;
         else if (is_data && addr_q[`CCAD_GATE_BIT])
         begin
            cyc_d.valid     = (tgt != ccad_pkg::CCAD_TGT_NONE);
            cyc_d.target    = tgt;
            cyc_d.is_config = 1'b1;
            cyc_d.type1     = type1;
            cyc_d.int_func  = int_func;
            cyc_d.addr      = route_addr;
         end
         else if (!is_addr)
            cyc_d.valid = 1'b1;
      end
   end

   // control state
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         state_q <= CCAD_IDLE;
      else
      begin
         unique case (state_q)
            CCAD_IDLE:
               if (cyc_d.valid)
                  state_q <= CCAD_WAIT;
            CCAD_WAIT:
               if (cyc_done)
                  state_q <= CCAD_IDLE;
         endcase
      end
   end

   // downstream cycle register
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         cyc_q <= '0;
      else if (state_q == CCAD_IDLE)
         cyc_q <= cyc_d;
      else if (cyc_done)
         cyc_q <= '0;
   end

   // host answer
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h0000_0000;
         busy_q  <= 1'b0;
      end
      else
      begin
         ack_q   <= 1'b0;
         busy_q  <= (state_q == CCAD_IDLE) ? cyc_d.valid : !cyc_done;
         if (state_q == CCAD_WAIT && cyc_done)
         begin
            ack_q   <= 1'b1;
            rdata_q <= cyc_q.write ? 32'h0000_0000 : cyc_rdata;
         end
         else if (take && !cyc_d.valid)
         begin
            ack_q   <= 1'b1;
            if (is_addr)
               rdata_q <= io_req.write ? 32'h0000_0000 : addr_q;
            else
               rdata_q <= 32'hffff_ffff;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      gfx_primary_bus <= `CCAD_PRIMARY_BUS;
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         addr_sel_out <= `CCAD_ADDR_RESET;
      else
         addr_sel_out <= addr_q & `CCAD_WR_MASK;
   end

   assign io_ack   = ack_q;
   assign io_rdata = rdata_q;
   assign io_busy  = busy_q;
   assign cyc_out  = cyc_q;
endmodule : ccad_decoder
`default_nettype wire

/* File: ccad_hub_model.sv */
// downstream responder completing each cycle lat+1 cycles after it appears
`timescale 1ns/1ps
`default_nettype none
module ccad_hub_model
(
   // clock, reset, cycle and delay
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   input  wire ccad_pkg::ccad_cycle_t cyc_out,
   input  wire logic [3:0]            lat,
   // completion
   output logic                       cyc_done,
   output logic [31:0]                cyc_rdata
);
   logic [3:0] cnt_q;
   always_ff @(posedge core_clk)
   begin
      cnt_q    <= (!rst_n || cyc_done || !cyc_out.valid) ? 4'h0
                                                         : cnt_q + 4'h1;
      cyc_done <= rst_n && !cyc_done && cyc_out.valid && cnt_q == lat;
   end
   // data only holds with the done pulse
   assign cyc_rdata = cyc_out.addr
                      ^ (cyc_done ? 32'ha5a5_a5a5 : 32'h5a5a_5a5a);
endmodule : ccad_hub_model
`default_nettype wire

/* File: ccad_monitor.sv */
// assertions on the decoder ports
`timescale 1ns/1ps
`default_nettype none
module ccad_monitor
(
   // clock and reset
   input wire logic                   core_clk,
   input wire logic                   rst_n,
   // watched ports
   input wire ccad_pkg::ccad_io_req_t io_req,
   input wire logic                   io_ack,
   input wire logic [31:0]            io_rdata,
   input wire ccad_pkg::ccad_cycle_t  cyc_out,
   input wire logic [31:0]            addr_sel_out,
   input wire logic [7:0]             gfx_primary_bus
);
   logic        v_q;
   wire  [31:0] a  = addr_sel_out;
   wire         tk = io_req.valid && !v_q;
   wire         ad = tk && io_req.port == 16'h0cf8;
   wire         cf = tk && io_req.port == 16'h0cfc;
   wire         ig = a[23:16] == 8'h00 && a[15:11] < 5'h03
                     && a[10:8] != 3'h0;
   always_ff @(posedge core_clk)
      v_q <= io_req.valid;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   property wr_p;
      logic [31:0] d;
      (ad && io_req.write && io_req.byte_en == 4'hf, d = io_req.wdata)
         |=> io_ack ##1 a == (d & 32'h80ff_fffc);
   endproperty
   addr_write_a: assert property (wr_p)
      else $error("address write lost");
   part_pass_a: assert property (ad && io_req.byte_en != 4'hf
      |=> cyc_out.valid && !cyc_out.is_config) else $error("partial");
   gate_on_a: assert property (cf && a[31] && !ig
      |=> cyc_out.valid && cyc_out.is_config) else $error("no cycle");
   gate_off_a: assert property (cf && !a[31]
      |=> cyc_out.valid && !cyc_out.is_config) else $error("gate off");
   fn_ignore_a: assert property (cf && a[31] && ig
      |=> io_ack && !cyc_out.valid && io_rdata == 32'hffff_ffff)
      else $error("function not ignored");
   rsvd_zero_a: assert property ((a & 32'h7f00_0003) == 32'h0)
      else $error("reserved bits set");
   prim_zero_a: assert property (gfx_primary_bus == 8'h00)
      else $error("primary bus nonzero");
   gfx_sel_a: assert property (cyc_out.valid && !cyc_out.type1
      && cyc_out.target == ccad_pkg::CCAD_TGT_GFX |-> cyc_out.addr[31:11]
      == {a[15] ? 16'h0 : 16'h1 << a[14:11], 5'h00})
      else $error("device select wrong");
   cover property (cyc_out.valid && cyc_out.type1);
   cover property (cf && a[31] && ig);
   cover property (ad && io_req.byte_en != 4'hf);
endmodule : ccad_monitor
bind ccad_decoder ccad_monitor mon_u
(
   .core_clk(core_clk), .rst_n(rst_n), .io_req(io_req), .io_ack(io_ack),
   .io_rdata(io_rdata), .cyc_out(cyc_out), .addr_sel_out(addr_sel_out),
   .gfx_primary_bus(gfx_primary_bus)
);
`default_nettype wire

/* File: ccad_params.svh */
// constants for the configuration cycle address decoder
`ifndef CCAD_PARAMS_SVH
`define CCAD_PARAMS_SVH
`define CCAD_ADDR_PORT     16'h0cf8
`define CCAD_DATA_PORT     16'h0cfc
`define CCAD_ADDR_RESET    32'h0000_0000
`define CCAD_GATE_BIT      31
`define CCAD_BUS_HI        23
`define CCAD_BUS_LO        16
`define CCAD_DEV_HI        15
`define CCAD_DEV_LO        11
`define CCAD_FUNC_HI       10
`define CCAD_FUNC_LO       8
`define CCAD_REG_HI        7
`define CCAD_REG_LO        2
`define CCAD_WR_MASK       32'h80ff_fffc
`define CCAD_INT_DEV_LAST  5'h02
`define CCAD_PRIMARY_BUS   8'h00
`endif

/* File: ccad_pkg.sv */
// types for the configuration cycle address decoder
`default_nettype none
package ccad_pkg;
   typedef enum logic [2:0] {
      CCAD_TGT_NONE,
      CCAD_TGT_INTERNAL,
      CCAD_TGT_HUB_A,
      CCAD_TGT_HUB_B,
      CCAD_TGT_GFX,
      CCAD_TGT_IO_PASS
   } ccad_target_t;

   // host i/o request
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] port;
      logic [3:0]  byte_en;
      logic [31:0] wdata;
   } ccad_io_req_t;

   // outgoing downstream cycle
   typedef struct packed {
      logic         valid;
      ccad_target_t target;
      logic         is_config;
      logic         type1;
      logic         write;
      logic [1:0]   int_func;
      logic [31:0]  addr;
      logic [3:0]   byte_en;
      logic [31:0]  wdata;
   } ccad_cycle_t;
endpackage : ccad_pkg
`default_nettype wire

/* File: ccad_route.sv */
// combinational target and address decode of the address register
`timescale 1ns/1ps
`default_nettype none
`include "ccad_params.svh"
module ccad_route
(
   // address register and bridge windows
   input  wire logic [31:0]        addr_sel,
   input  wire logic [7:0]         gfx_sec_bus,
   input  wire logic [7:0]         gfx_sub_bus,
   input  wire logic [7:0]         hubb_sec_bus,
   input  wire logic [7:0]         hubb_sub_bus,
   // decode result
   output ccad_pkg::ccad_target_t  target,
   output logic                    type1,
   output logic [1:0]              int_func,
   output logic [31:0]             out_addr
);
   logic [7:0] bus;
   logic [4:0] dev;
   logic [2:0] func;
   logic [5:0] regn;
   logic       gfx_t0;
   logic       gfx_t1;
   logic       hb_t0;
   logic       hb_t1;

   assign bus  = addr_sel[`CCAD_BUS_HI:`CCAD_BUS_LO];
   assign dev  = addr_sel[`CCAD_DEV_HI:`CCAD_DEV_LO];
   assign func = addr_sel[`CCAD_FUNC_HI:`CCAD_FUNC_LO];
   assign regn = addr_sel[`CCAD_REG_HI:`CCAD_REG_LO];

   function automatic logic in_range(input logic [7:0] b,
                                     input logic [7:0] lo,
                                     input logic [7:0] hi);
      in_range = (b > lo) && (b <= hi);
   endfunction : in_range

   // type 1 address: bus, device, function, register, then 01
   function automatic logic [31:0] t1_addr(input logic [31:0] s);
      t1_addr = {8'h00, s[23:2], 2'b01};
   endfunction : t1_addr

   assign gfx_t0 = (bus == gfx_sec_bus);
   assign gfx_t1 = in_range(bus, gfx_sec_bus, gfx_sub_bus);
   assign hb_t0  = (bus == hubb_sec_bus);
   assign hb_t1  = in_range(bus, hubb_sec_bus, hubb_sub_bus);

   always_comb
   begin
      target   = ccad_pkg::CCAD_TGT_HUB_A;
      type1    = 1'b0;
      int_func = dev[1:0];
      out_addr = {16'h0000, dev, func, regn, 2'b00};
      if (bus == `CCAD_PRIMARY_BUS)
      begin
         if (dev <= `CCAD_INT_DEV_LAST)
         begin
            if (func == 3'h0)
               target = ccad_pkg::CCAD_TGT_INTERNAL;
            else
               target = ccad_pkg::CCAD_TGT_NONE;
         end
         else
            target = ccad_pkg::CCAD_TGT_HUB_A;
      end
      else if (gfx_t0 || gfx_t1)
      begin
         target = ccad_pkg::CCAD_TGT_GFX;
         type1  = gfx_t1 && !gfx_t0;
         if (gfx_t0)
         begin
            if (!dev[4])
               out_addr[31:16] = 16'h0001 << dev[3:0];
            out_addr[15:11] = 5'h00;
         end
         else
            out_addr = t1_addr(addr_sel);
      end
      else if (hb_t0 || hb_t1)
      begin
         target = ccad_pkg::CCAD_TGT_HUB_B;
         type1  = hb_t1 && !hb_t0;
         if (type1)
            out_addr = t1_addr(addr_sel);
      end
      else
      begin
         target   = ccad_pkg::CCAD_TGT_HUB_A;
         type1    = 1'b1;
         out_addr = t1_addr(addr_sel);
      end
   end
endmodule : ccad_route
`default_nettype wire

/* File: tb_config_cycle_address_decoder.sv */
// self-checking bench for the config cycle address decoder
`timescale 1ns/1ps
`default_nettype none
module tb_config_cycle_address_decoder;
   logic                   core_clk = 1'b0;
   logic                   rst_n = 1'b0;
   logic                   ack, done, busy;
   logic [3:0]             lat = 4'h0;
   logic [7:0]             prim;
   logic [31:0]            rd, rdat, asel;
   ccad_pkg::ccad_io_req_t req = '0;
   ccad_pkg::ccad_cycle_t  cyc, cy;
   int                     n_fail = 0, n_checks = 0;
   // per case: bus, device, target code, type 1
   logic [63:0]            bs = 64'h0220_0908_0402_0000;
   logic [63:0]            dv = 64'h110a_061f_0704_0103;
   logic [31:0]            tg = 32'h4233_4412;
   logic [7:0]             t1 = 8'h68;
   always #12.5 core_clk = ~core_clk;
   ccad_decoder dut_u
   (
      .core_clk(core_clk), .rst_n(rst_n), .io_req(req),
      .gfx_sec_bus(8'h02), .gfx_sub_bus(8'h05), .hubb_sec_bus(8'h08),
      .hubb_sub_bus(8'h09), .cyc_done(done), .cyc_rdata(rdat),
      .io_ack(ack), .io_rdata(rd), .io_busy(busy), .cyc_out(cyc),
      .addr_sel_out(asel), .gfx_primary_bus(prim)
   );
   ccad_hub_model hub_u
   (
      .core_clk(core_clk), .rst_n(rst_n), .cyc_out(cyc), .lat(lat),
      .cyc_done(done), .cyc_rdata(rdat)
   );
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("Error t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic io(input logic w, input logic [15:0] p,
                     input logic [3:0] b, input logic [31:0] d);
      int n = 0;
      cy = '0;
      @(posedge core_clk);
      #1;
      req = '{1'b1, w, p, b, d};
      // sample settled outputs; drop valid in the ack cycle or it is retaken
      do
      begin
         @(posedge core_clk);
         #1;
         n++;
         if (cyc.valid === 1'b1)
         begin
            cy = cyc;
            chk({31'h0, busy}, 32'h1);
         end
      end
      while (ack !== 1'b1 && n < 40);
      chk({31'h0, ack}, 32'h1);
      chk({31'h0, busy}, 32'h0);
      req.valid = 1'b0;
   endtask : io
   task automatic t_reg;
      chk(asel, 32'h0);
      chk({24'h0, prim}, 32'h0);
      io(1'b1, 16'h0cf8, 4'hf, 32'hffff_ffff);
      io(1'b0, 16'h0cf8, 4'hf, 32'h0);
      chk(rd, 32'h80ff_fffc);
      io(1'b1, 16'h0cf8, 4'h3, 32'h0);
      chk({29'h0, cy.target}, 32'h5);
      chk(asel, 32'h80ff_fffc);
   endtask : t_reg
   task automatic t_gate;
      io(1'b1, 16'h0cf8, 4'hf, 32'h0000_1800);
      io(1'b0, 16'h0cfc, 4'hf, 32'h0);
      chk({28'h0, cy.is_config, cy.target}, 32'h5);
      io(1'b1, 16'h0cf8, 4'hf, 32'h8000_1200);
      io(1'b0, 16'h0cfc, 4'hf, 32'h0);
      chk(rd, 32'hffff_ffff);
      chk({31'h0, cy.valid}, 32'h0);
   endtask : t_gate
   task automatic t_route;
      logic [31:0] a;
      logic [31:0] e;
      logic [2:0]  t;
      for (int i = 0; i < 8; i++)
      begin
         t   = tg[4*i+:3];
         lat = i[3:0];
         a   = {8'h80, bs[8*i+:8], dv[8*i+:5], t == 3'h1 ? 3'h0 : 3'h6,
                8'h14};
         io(1'b1, 16'h0cf8, 4'hf, a);
         io(i[0], 16'h0cfc, 4'hf, ~a);
         chk(32'(cy.target), 32'(t));
         e = 32'({1'b1, t1[i]});
         chk(32'({cy.is_config, cy.type1}), e);
         chk(32'({cy.write, cy.byte_en}), 32'({i[0], 4'hf}));
         if (t == 3'h1)
            chk(32'(cy.int_func), 32'(dv[8*i+:2]));
         if (t1[i])
            e = {8'h00, a[23:2], 2'h1};
         else if (t == 3'h4)
            e = {a[15] ? 16'h0 : 16'h1 << a[14:11], 5'h00, a[10:2], 2'h0};
         else
            e = {16'h0, a[15:2], 2'h0};
         if (t != 3'h1)
            chk(cy.addr, e);
         if (i[0])
            chk(cy.wdata, ~a);
         else if (t != 3'h1)
            chk(rd, e ^ 32'ha5a5_a5a5);
      end
   endtask : t_route
   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      repeat (3) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      t_reg;
      t_gate;
      t_route;
      tally_and_finish;
   end
   initial
   begin
      #200000;
      n_fail++;
      tally_and_finish;
   end
endmodule : tb_config_cycle_address_decoder
`default_nettype wire
